/* File: psp_pkg.sv */
// Package: constants and types for the phrase sequence player
`default_nettype none
package psp_pkg;
  localparam int CLK_HZ = 100000000;
  // Item layout of one sequence table entry
  localparam int ITEM_W = 8;
  localparam int ITEMS_PER_ENTRY = 8;
  localparam int INDEX_W = 6;
  localparam logic [5:0] INDEX_MIN = 6'h01;
  localparam logic [5:0] INDEX_MAX = 6'h3F;
  // Item encoding: bit7 silence, bits5:0 phrase or silence units
  localparam int ITEM_SIL_BIT = 7;
  localparam logic [7:0] ITEM_END = 8'h00;
  // Timing
  localparam int SIL_UNIT_MS = 32;
  localparam int SIL_MAX_MS = 2016;
  localparam int STANDBY_TIMEOUT_MS = 250;
  localparam int DAC_RAMP_TIME_MS = 64;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int SIL_UNIT_CYCLES = SIL_UNIT_MS * MS_CYCLES;
  localparam int STANDBY_CYCLES = STANDBY_TIMEOUT_MS * MS_CYCLES;
  localparam int RAMP_CYCLES = DAC_RAMP_TIME_MS * MS_CYCLES;
  localparam int DIV_MIN = 256;
  localparam int DIV_MAX = 1024;
  // DAC codes (10 bit)
  localparam logic [9:0] DAC_ZERO = 10'h000;
  localparam logic [9:0] DAC_MID = 10'h200;
  localparam int RAMP_STEPS = 512;

  typedef enum {ST_STANDBY, ST_RAMP_UP, ST_FETCH, ST_PLAY, ST_SILENCE,
    ST_IDLE, ST_RAMP_DOWN} psp_state_type;

  // Per-phrase header from voice storage
  typedef struct packed {
    logic nonlinear;
    logic [10:0] div_ratio;
    logic [15:0] start_addr;
    logic [15:0] length;
  } psp_phrase_type;

  typedef struct packed {
    logic playing;
    logic silent;
    logic standby;
    logic osc_run;
  } psp_status_type;
endpackage
`default_nettype wire

/* File: psp_player.sv */
// Phrase sequence player: table walk, silences, PCM output, standby
`default_nettype none
////////////////////////////////////////////////////////////////////////
module psp_player
  import psp_pkg::*;
#(
  parameter int STANDBY_CYC = psp_pkg::STANDBY_CYCLES,
  parameter int RAMP_CYC = psp_pkg::RAMP_CYCLES,
  parameter int SIL_UNIT_CYC = psp_pkg::SIL_UNIT_CYCLES
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Playback request
  input wire logic play_req,
  input wire logic [psp_pkg::INDEX_W-1:0] play_index,
  // Sequence table read (combinational ROM)
  output logic [8:0] table_addr,
  input wire logic [psp_pkg::ITEM_W-1:0] table_item,
  // Phrase header read
  output logic [5:0] phrase_sel,
  input wire psp_pkg::psp_phrase_type phrase_hdr,
  // Sample storage read
  output logic sample_rd,
  output logic [15:0] sample_addr,
  input wire logic [7:0] sample_data,
  // Outputs
  output logic [9:0] analog_current_out,
  output psp_pkg::psp_status_type status
);
  import psp_pkg::*;

  psp_state_type state_r, state_nxt;
  logic [2:0] item_r;
  logic [5:0] index_r;
  logic [31:0] tmr_r;
  logic [10:0] div_r;
  logic [15:0] left_r;
  logic [9:0] dac_r;
  psp_phrase_type hdr_r;
  logic [8:0] taddr_r;
  logic [5:0] psel_r;
  logic rd_r;
  logic [15:0] saddr_r;
  psp_status_type status_r;
  logic load_r;
  logic [2:0] req_sync_r;
  logic [5:0] idx_sync_r [3];

  ////////////////////////////////////////////////////////////////////////
  // Nonlinear expansion: finer steps near centre
  function automatic logic [9:0] decode(input logic nl, input logic [7:0] s);
    logic [6:0] m;
    logic [9:0] mag;
    m = s[7] ? s[6:0] : ~s[6:0];
    mag = 10'h000;
    if (!nl)
      decode = {s, 2'b00};
    else
    begin
      if (m < 7'h40)
        mag = {3'b000, m};
      else if (m < 7'h60)
        mag = 10'h040 + {2'b00, m - 7'h40, 1'b0};
      else
        mag = 10'h080 + {1'b0, m - 7'h60, 2'b00};
      decode = s[7] ? DAC_MID + mag : DAC_MID - 10'h001 - mag;
    end
  endfunction

  // Request counts once stages two and three agree
  wire [5:0] idx_in = idx_sync_r[2];
  wire req_seen = req_sync_r[1] && req_sync_r[2] &&
    idx_sync_r[1] == idx_in;
  wire req_ok = req_seen && idx_in >= INDEX_MIN;
  wire item_sil = table_item[ITEM_SIL_BIT];
  wire item_end = table_item == ITEM_END;
  wire [5:0] sil_units = table_item[5:0];
  wire [31:0] ramp_step = RAMP_CYC / RAMP_STEPS;
  wire step_due = tmr_r >= ramp_step - 32'd1;
  wire at_mid = dac_r == DAC_MID;
  wire at_zero = dac_r == DAC_ZERO;
  wire last_item = item_r == 3'(ITEMS_PER_ENTRY - 1);
  wire div_wrap = div_r == hdr_r.div_ratio - 11'h001;
  wire unit_due = tmr_r >= 32'(SIL_UNIT_CYC - 1);
  wire play_done = state_r == ST_PLAY && !load_r && left_r == 16'h0000 &&
    div_wrap;
  wire sil_done = state_r == ST_SILENCE && left_r == 16'h0001 && unit_due;
  wire item_done = play_done || sil_done;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; index crosses alongside the request
  always_ff @(posedge clock)
  begin
    req_sync_r <= {req_sync_r[1:0], play_req};
    idx_sync_r[0] <= play_index;
    idx_sync_r[1] <= idx_sync_r[0];
    idx_sync_r[2] <= idx_sync_r[1];
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STANDBY: if (req_ok) state_nxt = ST_RAMP_UP;
      ST_RAMP_UP: if (at_mid) state_nxt = ST_FETCH;
      ST_FETCH:
        if (item_end) state_nxt = ST_IDLE;
        else if (item_sil) state_nxt = ST_SILENCE;
        else state_nxt = ST_PLAY;
      ST_PLAY, ST_SILENCE:
        if (item_done) state_nxt = last_item ? ST_IDLE : ST_FETCH;
      ST_IDLE:
        if (req_ok) state_nxt = ST_FETCH;
        else if (tmr_r >= 32'(STANDBY_CYC - 1)) state_nxt = ST_RAMP_DOWN;
      ST_RAMP_DOWN:
        if (req_ok) state_nxt = ST_RAMP_UP;
        else if (at_zero) state_nxt = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clock)
  begin
    rd_r <= 1'b0;
    if (rst)
    begin
      state_r <= ST_STANDBY;
      item_r <= 3'h0;
      index_r <= 6'h00;
      tmr_r <= 32'h0;
      div_r <= 11'h000;
      left_r <= 16'h0000;
      dac_r <= DAC_ZERO;
      hdr_r <= '0;
      taddr_r <= 9'h000;
      psel_r <= 6'h00;
      saddr_r <= 16'h0000;
      status_r <= '0;
      load_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tmr_r <= tmr_r + 32'h1;
      unique case (state_r)
        ST_STANDBY, ST_IDLE, ST_RAMP_DOWN:
        begin
          if (req_ok)
          begin
            index_r <= idx_in;
            item_r <= 3'h0;
            taddr_r <= {idx_in, 3'h0};
            tmr_r <= 32'h0;
          end
          if (state_r == ST_RAMP_DOWN && step_due)
          begin
            tmr_r <= 32'h0;
            if (!at_zero) dac_r <= dac_r - 10'h001;
          end
        end
        ST_RAMP_UP:
          if (step_due)
          begin
            tmr_r <= 32'h0;
            if (!at_mid) dac_r <= dac_r + 10'h001;
          end
        ST_FETCH:
        begin
          tmr_r <= 32'h0;
          load_r <= !item_end && !item_sil;
          if (item_sil)
            left_r <= {10'h000, sil_units};
        end
        ST_PLAY:
          if (load_r)
          begin
            // Header a cycle late: phrase_sel lags the table by one
            load_r <= 1'b0;
            hdr_r <= phrase_hdr;
            saddr_r <= phrase_hdr.start_addr;
            left_r <= phrase_hdr.length;
            div_r <= 11'h000;
          end
          else
          begin
            div_r <= div_r + 11'h001;
            if (div_wrap)
            begin
              div_r <= 11'h000;
              if (left_r == 16'h0000)
                dac_r <= DAC_MID;
              else
              begin
                rd_r <= 1'b1;
                dac_r <= decode(hdr_r.nonlinear, sample_data);
                saddr_r <= saddr_r + 16'h0001;
                left_r <= left_r - 16'h0001;
              end
            end
          end
        ST_SILENCE:
        begin
          dac_r <= DAC_MID;
          if (tmr_r >= 32'(SIL_UNIT_CYC - 1))
          begin
            tmr_r <= 32'h0;
            left_r <= left_r - 16'h0001;
          end
        end
        default: ;
      endcase
      // Item advance after phrase or silence ends
      if (item_done)
      begin
        tmr_r <= 32'h0;
        item_r <= item_r + 3'h1;
        taddr_r <= {index_r, item_r + 3'h1};
      end
      psel_r <= table_item[5:0];
      status_r.playing <= state_nxt inside {ST_FETCH, ST_PLAY, ST_SILENCE};
      status_r.silent <= state_nxt == ST_SILENCE;
      status_r.standby <= state_nxt == ST_STANDBY;
      status_r.osc_run <= state_nxt != ST_STANDBY;
    end
  end

  assign table_addr = taddr_r;
  assign phrase_sel = psel_r;
  assign sample_rd = rd_r;
  assign sample_addr = saddr_r;
  assign analog_current_out = dac_r;
  assign status = status_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sil_mid_a: assert property (state_r == ST_SILENCE |=>
    dac_r == DAC_MID) else $error("silence not at mid level");
  ramp_wait_a: assert property (state_r == ST_RAMP_UP && !at_mid |=>
    state_r != ST_PLAY) else $error("voice before mid level");
  sil_nofetch_a: assert property (state_r == ST_SILENCE |->
    !rd_r) else $error("silence read samples");
  req_start_a: assert property (state_r == ST_STANDBY && req_ok |=>
    state_r == ST_RAMP_UP && index_r == $past(idx_in))
    else $error("request not taken");
  bad_idx_a: assert property (state_r == ST_STANDBY && req_seen &&
    idx_in == 6'h00 |=> state_r == ST_STANDBY)
    else $error("index zero started");
  hdr_sel_a: assert property (state_r == ST_PLAY && load_r |->
    phrase_sel == table_item[5:0]) else $error("header of wrong phrase");
  standby_a: assert property (state_r == ST_RAMP_DOWN && at_zero &&
    !req_ok |=> state_r == ST_STANDBY) else $error("no standby");
  ramp_step_a: assert property (state_r == ST_RAMP_UP |=>
    dac_r - $past(dac_r) <= 10'h001) else $error("ramp too fast");
  item_count_a: assert property (state_r == ST_FETCH |->
    table_addr[8:3] == index_r) else $error("left entry");
  rate_a: assert property (state_r == ST_PLAY && rd_r |->
    div_r == 11'h000) else $error("sample off rate");
  cover_play_c: cover property (state_r == ST_FETCH ##1 state_r == ST_PLAY);
  cover_sil_c: cover property (state_r == ST_SILENCE ##1
    state_r == ST_FETCH);
  cover_wake_c: cover property (state_r == ST_RAMP_DOWN ##1
    state_r == ST_RAMP_UP);
endmodule // psp_player
`default_nettype wire

/* File: psp_rom_model.sv */
// Behavioural table, header and sample ROMs facing the player
`default_nettype none
module psp_rom_model
  import psp_pkg::*;
(
  // Sequence table
  input wire logic [8:0] table_addr,
  output logic [7:0] table_item,
  // Phrase header and samples
  input wire logic [5:0] phrase_sel,
  output psp_pkg::psp_phrase_type phrase_hdr,
  input wire logic [15:0] sample_addr,
  output logic [7:0] sample_data
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [5:0] idx = table_addr[8:3];
  wire logic [2:0] pos = table_addr[2:0];
  wire logic [7:0] seq_one = (pos == 3'h0) ? 8'h01 : (pos == 3'h1) ? 8'h82
    : (pos == 3'h2) ? 8'h02 : 8'h00;
  // Index 1: phrase, two-unit silence, phrase; index 3: eight phrases
  assign table_item = (idx == 6'h01) ? seq_one
    : (idx == 6'h03) ? ({5'h00, pos} + 8'h01) : 8'h00;
  // Odd phrases non-linear; phrase 2 at the slowest rate
  assign phrase_hdr = '{nonlinear: phrase_sel[0],
    div_ratio: (phrase_sel == 6'h02) ? 11'h400 : 11'h100,
    start_addr: {6'h00, phrase_sel, 4'h0}, length: 16'h0004};
  // Data changes with address so a stale read shows
  assign sample_data = sample_addr[7:0] ^ 8'hA5;
endmodule // psp_rom_model
`default_nettype wire

/* File: test_psp_player.sv */
// Self-checking bench for the phrase sequence player
`default_nettype none
module test_psp_player;
  import psp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic play_req = 1'b0;
  logic [5:0] play_index = 6'h00;
  logic [8:0] table_addr;
  logic [7:0] table_item;
  logic [5:0] phrase_sel;
  psp_phrase_type phrase_hdr;
  logic sample_rd;
  logic [15:0] sample_addr;
  logic [7:0] sample_data;
  logic [9:0] analog_current_out;
  psp_status_type status;
  int bad_count = 0;
  int checks = 0;
  int rd_count = 0;
  int sil_count = 0;
  int sil_bad = 0;
  int cyc = 0;
  int n;
  int base;
  psp_player #(.STANDBY_CYC(200), .RAMP_CYC(1024), .SIL_UNIT_CYC(20))
    psp_player_i (.clock(clock), .rst(rst), .play_req(play_req),
    .play_index(play_index), .table_addr(table_addr),
    .table_item(table_item), .phrase_sel(phrase_sel),
    .phrase_hdr(phrase_hdr), .sample_rd(sample_rd),
    .sample_addr(sample_addr), .sample_data(sample_data),
    .analog_current_out(analog_current_out), .status(status));
  psp_rom_model psp_rom_model_i (.table_addr(table_addr),
    .table_item(table_item), .phrase_sel(phrase_sel),
    .phrase_hdr(phrase_hdr), .sample_addr(sample_addr),
    .sample_data(sample_data));
  initial
  begin
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  // Monitor; silence must neither read samples nor leave mid level
  always @(posedge clock)
  begin
    cyc++;
    if (sample_rd === 1'b1) rd_count++;
    if (status.silent === 1'b1) sil_count++;
    if (status.silent === 1'b1 && (sample_rd !== 1'b0
      || analog_current_out !== DAC_MID)) sil_bad++;
    if (cyc == 60000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s got %0h", $time, what, got);
    end
  endtask
  // Held two edges so both synchroniser stages agree once
  task automatic req(input logic [5:0] idx);
    @(posedge clock);
    play_req <= 1'b1;
    play_index <= idx;
    repeat (2) @(posedge clock);
    play_req <= 1'b0;
  endtask
  // Kind 0: mid level; 1: playback over; 2: standby
  task automatic wait_for(input int kind, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < lim)
    begin
      @(posedge clock);
      #1;
      cnt++;
      hit = (kind == 0) ? analog_current_out === DAC_MID
        : (kind == 1) ? status.playing === 1'b0 : status.standby === 1'b1;
    end
    chk({31'h0, hit}, 32'h1, "wait limit");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_ramp_and_sequence();
    base = rd_count;
    req(6'h01);
    wait_for(0, 2000, n);
    chk(rd_count - base, 0, "read before mid");
    chk({31'h0, n > 1000 && n < 1050}, 1, "ramp length");
    repeat (5) @(posedge clock);
    wait_for(1, 9000, n);
    chk(rd_count - base, 8, "sample reads");
    chk({31'h0, sil_count > 38 && sil_count < 42}, 1, "silence");
    chk(sil_bad, 0, "silence output");
  endtask
  task automatic t_standby_and_index0();
    wait_for(2, 1400, n);
    chk({31'h0, n > 1190 && n < 1260}, 1, "standby delay");
    chk(analog_current_out, DAC_ZERO, "standby level");
    chk(status.osc_run, 1'b0, "osc stopped");
    req(6'h00);
    repeat (50) @(posedge clock);
    chk(status.standby, 1'b1, "index 0");
  endtask
  task automatic t_full_then_wake();
    base = rd_count;
    req(6'h3F);
    wait_for(0, 2000, n);
    repeat (5) @(posedge clock);
    wait_for(1, 100, n);
    chk(rd_count - base, 0, "empty entry");
    req(6'h03);
    repeat (5) @(posedge clock);
    wait_for(1, 16000, n);
    chk(rd_count - base, 32, "eight items");
    repeat (500) @(posedge clock);
    chk({31'h0, analog_current_out < DAC_MID}, 1, "ramping down");
    base = rd_count;
    req(6'h01);
    wait_for(0, 2000, n);
    chk(rd_count - base, 0, "wake read");
    repeat (5) @(posedge clock);
    chk(status.playing, 1'b1, "wake playing");
    wait_for(1, 9000, n);
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(analog_current_out, DAC_ZERO, "reset level");
    t_ramp_and_sequence();
    t_standby_and_index0();
    t_full_then_wake();
    give_verdict();
  end
endmodule // test_psp_player
`default_nettype wire
